// file: hdl/phc_pkg.sv
package phc_pkg;

	// ********************************
	// bus addressing and register map
	// ********************************
	localparam logic [2:0] ADDR_FIXED       = 3'h2;
	localparam logic [7:0] OFS_EVENT        = 8'h00;
	localparam logic [7:0] OFS_MASK         = 8'h01;
	localparam logic [7:0] OFS_PINSTAT      = 8'h11;
	localparam logic [7:0] OFS_ACEN         = 8'h13;
	localparam logic [7:0] OFS_PUSHBUTTON   = 8'h1A;

	// ********************************
	// reset values and fields
	// ********************************
	localparam logic [7:0] MASK_RST_AUTO_LO = 8'h80;
	localparam logic [7:0] MASK_RST_AUTO_HI = 8'hE4;
	localparam logic [7:0] ACEN_RST         = 8'h00;
	localparam int         PB_RELEASE_LO    = 6;
	localparam int         PB_RELEASE_HI    = 7;
	localparam int         PINSTAT_AUTO     = 0;

	// ********************************
	// timing
	// ********************************
	localparam int         CLK_PERIOD_NS    = 5;
	localparam int         FILT_TIME_NS     = 1000;
	localparam int         FILT_CYC         = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] FILT_LAST        = 8'(FILT_CYC - 1);

	// ********************************
	// types
	// ********************************
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ADDR  = 3'h1,
		ST_AACK  = 3'h3,
		ST_WBYTE = 3'h2,
		ST_WACK  = 3'h6,
		ST_RBYTE = 3'h7,
		ST_RACK  = 3'h5
	} phc_state_e;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} phc_wr_s;

endpackage : phc_pkg

// file: hdl/phc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module phc_sync #(
	parameter int W = 1
) (
	// clock
	input  wire logic         core_clk,
	// pins in, synchronised out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// no reset: straps must be visible while reset is held
	logic [W-1:0] stage1;

	always_ff @(posedge core_clk)
	begin
		stage1 <= d;
		q      <= stage1;
	end

endmodule : phc_sync
`default_nettype wire

// file: hdl/phc_filt.sv
`timescale 1ns/10ps
`default_nettype none
module phc_filt (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// synchronised level in, filtered level out
	input  wire logic d,
	output logic      q
);

	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic       next_q;

	// output follows only after the input has differed for the full window
	always_comb
	begin
		next_q   = q;
		next_cnt = 8'h00;
		if (d != q)
		begin
			if (cnt == phc_pkg::FILT_LAST)
				next_q = d;
			else
				next_cnt = cnt + 8'h01;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			q   <= 1'b1;
			cnt <= 8'h00;
		end
		else
		begin
			q   <= next_q;
			cnt <= next_cnt;
		end
	end

	a_filter_stable : assert property (@(posedge core_clk) disable iff (rst)
		$changed(q) |-> ($past(d, 1) == q) && ($past(d, 8) == q))
		else $error("filtered level changed without a stable input");

endmodule : phc_filt
`default_nettype wire

// file: hdl/phc_top.sv
`timescale 1ns/10ps
`default_nettype none
module phc_top (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// reset and shutdown pins
	input  wire logic       chip_reset_n,
	input  wire logic       port1_off_n,
	input  wire logic       port2_off_n,
	input  wire logic       port3_off_n,
	input  wire logic       port4_off_n,
	// serial bus pins
	input  wire logic       scl_in,
	input  wire logic       serial_data_sense_in,
	output logic            serial_data_drive_out,
	output logic            serial_data_drive_out_oe,
	// straps
	input  wire logic       target_addr_strap_bit3,
	input  wire logic       target_addr_strap_bit2,
	input  wire logic       target_addr_strap_bit1,
	input  wire logic       target_addr_strap_bit0,
	input  wire logic       auto_mode_strap,
	// interrupt pin
	output logic            int_out,
	output logic            int_out_oe,
	// port logic side
	input  wire logic [7:0] event_in,
	input  wire logic       osc_missing_flag,
	output logic      [3:0] port_off,
	output logic      [3:0] ac_sense_valid
);

	// ********************************
	// pin synchronisers and filters
	// ********************************
	logic [11:0] pin_raw;
	logic [11:0] pin_s;
	logic        scl_s;
	logic        sda_s;
	logic        rstn_s;
	logic [3:0]  offn_s;
	logic [3:0]  strap_s;
	logic        auto_s;
	logic        rstn_f;
	logic [3:0]  offn_f;
	logic        rst_int;

	assign pin_raw = {scl_in, serial_data_sense_in, chip_reset_n,
		port4_off_n, port3_off_n, port2_off_n, port1_off_n,
		target_addr_strap_bit3, target_addr_strap_bit2,
		target_addr_strap_bit1, target_addr_strap_bit0, auto_mode_strap};

	phc_sync #(.W(12)) u_sync (
		.core_clk (core_clk),
		.d        (pin_raw),
		.q        (pin_s)
	);

	assign scl_s   = pin_s[11];
	assign sda_s   = pin_s[10];
	assign rstn_s  = pin_s[9];
	assign offn_s  = pin_s[8:5];
	assign strap_s = pin_s[4:1];
	assign auto_s  = pin_s[0];

	// glitch filter on the chip reset pin
	phc_filt u_rst_filt (
		.core_clk (core_clk),
		.rst      (rst),
		.d        (rstn_s),
		.q        (rstn_f)
	);

	assign rst_int = rst | ~rstn_f;

	generate
		for (genvar g = 0; g < 4; g++)
		begin : g_off
			phc_filt u_off_filt (
				.core_clk (core_clk),
				.rst      (rst),
				.d        (offn_s[g]),
				.q        (offn_f[g])
			);
		end
	endgenerate

	// ********************************
	// bus condition detection
	// ********************************
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	always_ff @(posedge core_clk)
	begin
		if (rst_int)
		begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

	// ********************************
	// register state
	// ********************************
	logic [7:0] event_stat;
	logic [7:0] event_mask_reg;
	logic [7:0] acen;
	logic       int_pend;

	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		case (a)
			phc_pkg::OFS_EVENT:   rd_mux = event_stat;
			phc_pkg::OFS_MASK:    rd_mux = event_mask_reg;
			phc_pkg::OFS_PINSTAT: rd_mux = {7'h00, auto_s};
			phc_pkg::OFS_ACEN:    rd_mux = acen;
			default:              rd_mux = 8'h00;
		endcase
	endfunction : rd_mux

	// ********************************
	// serial target state machine
	// ********************************
	phc_pkg::phc_state_e state;
	phc_pkg::phc_state_e next_state;
	logic [3:0]          bit_cnt;
	logic [3:0]          next_bit_cnt;
	logic [7:0]          shreg;
	logic [7:0]          next_shreg;
	logic [7:0]          ptr;
	logic [7:0]          next_ptr;
	logic                rw;
	logic                next_rw;
	logic                first;
	logic                next_first;
	logic                sda_oe;
	logic                next_sda_oe;
	logic                busy;
	logic                next_busy;
	phc_pkg::phc_wr_s    wr;
	phc_pkg::phc_wr_s    next_wr;

	always_comb
	begin
		next_state   = state;
		next_bit_cnt = bit_cnt;
		next_shreg   = shreg;
		next_ptr     = ptr;
		next_rw      = rw;
		next_first   = first;
		next_sda_oe  = sda_oe;
		next_busy    = busy;
		next_wr      = '0;
		if (bus_start)
		begin
			next_state   = phc_pkg::ST_ADDR;
			next_bit_cnt = 4'h0;
			next_sda_oe  = 1'b0;
			next_busy    = 1'b1;
		end
		else if (bus_stop)
		begin
			next_state  = phc_pkg::ST_IDLE;
			next_sda_oe = 1'b0;
			next_busy   = 1'b0;
		end
		else
		begin
			case (state)
				phc_pkg::ST_IDLE:
					next_sda_oe = 1'b0;
				phc_pkg::ST_ADDR:
				begin
					if (scl_rise)
					begin
						next_shreg   = {shreg[6:0], sda_s};
						next_bit_cnt = bit_cnt + 4'h1;
					end
					if (scl_fall && bit_cnt == 4'h8)
					begin
						if (shreg[7:1] == {phc_pkg::ADDR_FIXED, strap_s})
						begin
							next_state  = phc_pkg::ST_AACK;
							next_sda_oe = 1'b1;
							next_rw     = shreg[0];
						end
						else
							next_state = phc_pkg::ST_IDLE;
					end
				end
				phc_pkg::ST_AACK:
					if (scl_fall)
					begin
						next_bit_cnt = 4'h0;
						if (rw)
						begin
							next_shreg  = rd_mux(ptr);
							next_sda_oe = ~next_shreg[7];
							next_state  = phc_pkg::ST_RBYTE;
						end
						else
						begin
							next_sda_oe = 1'b0;
							next_first  = 1'b1;
							next_state  = phc_pkg::ST_WBYTE;
						end
					end
				phc_pkg::ST_WBYTE:
				begin
					if (scl_rise)
					begin
						next_shreg   = {shreg[6:0], sda_s};
						next_bit_cnt = bit_cnt + 4'h1;
					end
					if (scl_fall && bit_cnt == 4'h8)
					begin
						next_sda_oe = 1'b1;
						next_state  = phc_pkg::ST_WACK;
						next_first  = 1'b0;
						if (first)
							next_ptr = shreg;
						else
						begin
							next_wr  = '{en: 1'b1, addr: ptr, data: shreg};
							next_ptr = ptr + 8'h01;
						end
					end
				end
				phc_pkg::ST_WACK:
					if (scl_fall)
					begin
						next_sda_oe  = 1'b0;
						next_bit_cnt = 4'h0;
						next_state   = phc_pkg::ST_WBYTE;
					end
				phc_pkg::ST_RBYTE:
				begin
					if (scl_rise)
						next_bit_cnt = bit_cnt + 4'h1;
					if (scl_fall)
					begin
						if (bit_cnt == 4'h8)
						begin
							next_sda_oe = 1'b0;
							next_state  = phc_pkg::ST_RACK;
						end
						else
						begin
							next_shreg  = {shreg[6:0], 1'b0};
							next_sda_oe = ~shreg[6];
						end
					end
				end
				phc_pkg::ST_RACK:
				begin
					if (scl_rise && sda_s)
						next_state = phc_pkg::ST_IDLE;
					else if (scl_fall)
					begin
						next_ptr     = ptr + 8'h01;
						next_shreg   = rd_mux(ptr + 8'h01);
						next_sda_oe  = ~next_shreg[7];
						next_bit_cnt = 4'h0;
						next_state   = phc_pkg::ST_RBYTE;
					end
				end
				default:
					next_state = phc_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst_int)
		begin
			state   <= phc_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
			shreg   <= 8'h00;
			ptr     <= 8'h00;
			rw      <= 1'b0;
			first   <= 1'b0;
			sda_oe  <= 1'b0;
			busy    <= 1'b0;
			wr      <= '0;
		end
		else
		begin
			state   <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg   <= next_shreg;
			ptr     <= next_ptr;
			rw      <= next_rw;
			first   <= next_first;
			sda_oe  <= next_sda_oe;
			busy    <= next_busy;
			wr      <= next_wr;
		end
	end

	// ********************************
	// registers and interrupt
	// ********************************
	logic       pb_wr;
	logic       int_release;
	logic [7:0] next_event_stat;
	logic [7:0] next_event_mask_reg;
	logic [7:0] next_acen;
	logic       next_int_pend;

	assign pb_wr       = wr.en && wr.addr == phc_pkg::OFS_PUSHBUTTON;
	assign int_release = pb_wr && (wr.data[phc_pkg::PB_RELEASE_LO]
		|| wr.data[phc_pkg::PB_RELEASE_HI]);

	// a new event in the clearing cycle still lands
	always_comb
	begin
		next_event_stat = event_stat;
		if (pb_wr && wr.data[phc_pkg::PB_RELEASE_HI])
			next_event_stat = 8'h00;
		next_event_stat     = next_event_stat | event_in;
		next_int_pend       = (int_pend & ~int_release) | (|(event_in & event_mask_reg));
		next_event_mask_reg = event_mask_reg;
		next_acen           = acen;
		if (wr.en && wr.addr == phc_pkg::OFS_MASK)
			next_event_mask_reg = wr.data;
		if (wr.en && wr.addr == phc_pkg::OFS_ACEN)
			next_acen = wr.data;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst_int)
		begin
			event_stat     <= 8'h00;
			event_mask_reg <= auto_s ? phc_pkg::MASK_RST_AUTO_HI : phc_pkg::MASK_RST_AUTO_LO;
			acen           <= phc_pkg::ACEN_RST;
			int_pend       <= 1'b0;
		end
		else
		begin
			event_stat     <= next_event_stat;
			event_mask_reg <= next_event_mask_reg;
			acen           <= next_acen;
			int_pend       <= next_int_pend;
		end
	end

	// ********************************
	// output pins
	// ********************************
	logic       next_int_out_oe;
	logic [3:0] next_port_off;
	logic [3:0] next_ac_sense_valid;

	always_comb
	begin
		// pin frozen while the bus is busy so the host reads a stable line
		next_int_out_oe     = busy ? int_out_oe : int_pend;
		next_port_off       = ~offn_f | (pb_wr ? wr.data[3:0] : 4'h0);
		next_ac_sense_valid = {4{~osc_missing_flag}} & acen[3:0];
		if (rst_int)
		begin
			next_int_out_oe     = 1'b0;
			next_port_off       = 4'hF;
			next_ac_sense_valid = 4'h0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			int_out_oe               <= 1'b0;
			port_off                 <= 4'hF;
			ac_sense_valid           <= 4'h0;
			serial_data_drive_out_oe <= 1'b0;
		end
		else
		begin
			int_out_oe               <= next_int_out_oe;
			port_off                 <= next_port_off;
			ac_sense_valid           <= next_ac_sense_valid;
			serial_data_drive_out_oe <= sda_oe;
		end
	end

	// open-drain pins only ever pull low
	always_ff @(posedge core_clk)
	begin
		int_out               <= 1'b0;
		serial_data_drive_out <= 1'b0;
	end

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_reset_ports_off : assert property (rst_int |=> port_off == 4'hF && !int_out_oe)
		else $error("reset did not hold ports off");
	a_int_pull_cause : assert property ($rose(int_out_oe) |-> $past(int_pend) && !$past(busy))
		else $error("interrupt pulled low without a pending event");
	a_int_release_pb : assert property (int_release && !(|(event_in & event_mask_reg))
		|=> !int_pend)
		else $error("interrupt not released after pushbutton write");
	a_int_follow_idle : assert property (!busy && !rst_int |=> int_out_oe == $past(int_pend))
		else $error("interrupt pin did not follow pending state between transfers");
	a_mask_blocks : assert property (!rst_int && !int_pend && !(|(event_in & event_mask_reg))
		|=> !int_pend)
		else $error("masked event raised interrupt");
	a_int_frozen_busy : assert property (busy && $past(busy) |-> $stable(int_out_oe))
		else $error("interrupt pin changed during a transaction");
	a_addr_match : assert property ($rose(state == phc_pkg::ST_AACK)
		|-> $past(shreg[7:1]) == {phc_pkg::ADDR_FIXED, strap_s})
		else $error("acknowledged a foreign address");
	a_sda_drive_states : assert property (serial_data_drive_out_oe |-> $past(state)
		inside {phc_pkg::ST_AACK, phc_pkg::ST_WACK, phc_pkg::ST_RBYTE} && !serial_data_drive_out)
		else $error("data driven outside acknowledge or read");
	a_shdn_off : assert property (!rst_int |=> (port_off | $past(offn_f)) == 4'hF)
		else $error("shutdown input did not turn port off");
	a_ac_valid : assert property (ac_sense_valid != 4'h0 |-> !$past(osc_missing_flag)
		&& ((ac_sense_valid & ~$past(acen[3:0])) == 4'h0))
		else $error("ac sense valid without enable or oscillator");
	a_mask_reset_val : assert property ($past(rst_int) && !rst_int |-> event_mask_reg ==
		($past(auto_s) ? phc_pkg::MASK_RST_AUTO_HI : phc_pkg::MASK_RST_AUTO_LO))
		else $error("mask reset value does not follow auto strap");
	a_int_never_high : assert property (int_out == 1'b0)
		else $error("interrupt pin driven high");

endmodule : phc_top
`default_nettype wire

// file: tb/phc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************
// serial bus controller model
// ********************************
module phc_host_model (
	// clock
	input  wire logic core_clk,
	// bus lines, data released to pull-up
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low
);
	bit busy;
	initial
	begin
		scl_out = 1'b1;
		sda_low = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wt
	// 12 cycles low, 13 high: 125 ns; data moves only while clock low
	task automatic bit_x(input logic b, output logic r);
		scl_out <= 1'b0;
		wt(6);
		sda_low <= ~b;
		wt(6);
		scl_out <= 1'b1;
		wt(7);
		r = sda_in;
		wt(6);
	endtask : bit_x
	// clock stands high between frames, so only a repeated start pulses it
	task automatic start();
		if (busy)
		begin
			scl_out <= 1'b0;
			wt(6);
			sda_low <= 1'b0;
			wt(6);
			scl_out <= 1'b1;
			wt(13);
		end
		sda_low <= 1'b1;
		wt(13);
		busy = 1'b1;
	endtask : start
	task automatic stop();
		scl_out <= 1'b0;
		wt(6);
		sda_low <= 1'b1;
		wt(6);
		scl_out <= 1'b1;
		wt(13);
		sda_low <= 1'b0;
		wt(13);
		busy = 1'b0;
	endtask : stop
	// ninth bit released: target acks on writes, we nack single reads
	task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_x(tx[i], rx[i]);
		bit_x(1'b1, a);
		ack = ~a;
	endtask : byte_x
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d,
		output logic ok);
		logic [7:0] r;
		logic       k1, k2, k3;
		start();
		byte_x({a, 1'b0}, r, k1);
		byte_x(ofs, r, k2);
		byte_x(d, r, k3);
		stop();
		ok = k1 & k2 & k3;
	endtask : wr_reg
	task automatic rd_reg(input logic [6:0] a, input logic [7:0] ofs, output logic [7:0] d);
		logic [7:0] r;
		logic       k;
		start();
		byte_x({a, 1'b0}, r, k);
		byte_x(ofs, r, k);
		start();
		byte_x({a, 1'b1}, r, k);
		byte_x(8'hFF, d, k);
		stop();
	endtask : rd_reg
endmodule : phc_host_model
`default_nettype wire

// file: tb/pse_host_control_pins_bench.sv
`timescale 1ns/10ps
`default_nettype none
module pse_host_control_pins_bench;
	logic       core_clk, rst, chip_reset_n, osc, auto, clr_seen, ok;
	logic [3:0] off_n, strap, seen_off, n;
	logic [7:0] event_in, rd, exp_v;
	logic [6:0] addr;
	wire logic  scl, sda_low, sdo, oe, iout, ioe;
	wire logic [3:0] port_off, acv;
	int         fail_count, checks, cycles, p;
	// open-drain data line with pull-up
	wire logic  sda = ~(sda_low | oe);
	phc_top i_phc_top (.core_clk(core_clk), .rst(rst), .chip_reset_n(chip_reset_n),
		.port1_off_n(off_n[0]), .port2_off_n(off_n[1]), .port3_off_n(off_n[2]),
		.port4_off_n(off_n[3]), .scl_in(scl), .serial_data_sense_in(sda),
		.serial_data_drive_out(sdo), .serial_data_drive_out_oe(oe),
		.target_addr_strap_bit3(strap[3]), .target_addr_strap_bit2(strap[2]),
		.target_addr_strap_bit1(strap[1]), .target_addr_strap_bit0(strap[0]),
		.auto_mode_strap(auto), .int_out(iout), .int_out_oe(ioe), .event_in(event_in),
		.osc_missing_flag(osc), .port_off(port_off), .ac_sense_valid(acv));
	phc_host_model i_phc_host_model (.core_clk(core_clk), .sda_in(sda), .scl_out(scl),
		.sda_low(sda_low));
	// ********************************
	// helpers
	// ********************************
	function automatic logic [7:0] mask_rst(input logic a);
		return a ? phc_pkg::MASK_RST_AUTO_HI : phc_pkg::MASK_RST_AUTO_LO;
	endfunction : mask_rst
	task automatic wrap_up;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wt(input int k);
		repeat (k) @(posedge core_clk);
	endtask : wt
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		i_phc_host_model.wr_reg(addr, ofs, d, ok);
		chk({7'h0, ok}, 8'h01, "write ack");
	endtask : wr
	task automatic rdr(input logic [7:0] ofs);
		i_phc_host_model.rd_reg(addr, ofs, rd);
	endtask : rdr
	task automatic pulse(input logic [7:0] v);
		event_in <= v;
		wt(1);
		event_in <= 8'h00;
		wt(1);
	endtask : pulse
	task automatic clr;
		clr_seen <= 1'b1;
		wt(1);
		clr_seen <= 1'b0;
		wt(1);
	endtask : clr
	// ********************************
	// clock, watchdog, pin monitors
	// ********************************
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		seen_off <= clr_seen ? 4'h0 : (seen_off | port_off);
		cycles++;
		if (!rst)
			chk({6'h0, sdo, iout}, 8'h00, "pins driven high");
		if (cycles == 40000)
		begin
			fail_count++;
			$display("MISMATCH %0t timeout", $time);
			wrap_up();
		end
	end
	// ********************************
	// scenarios
	// ********************************
	initial
	begin
		rst = 1'b1;
		chip_reset_n = 1'b1;
		off_n = 4'hF;
		osc = 1'b0;
		event_in = 8'h00;
		clr_seen = 1'b0;
		void'($urandom(32'h6d37a20b));
		strap = 4'($urandom);
		auto = 1'($urandom);
		addr = {phc_pkg::ADDR_FIXED, strap};
		wt(6);
		rst <= 1'b0;
		wt(220);
		rdr(phc_pkg::OFS_MASK);
		chk(rd, mask_rst(auto), "mask reset");
		for (int k = 0; k < 2; k++)
		begin
			rdr(phc_pkg::OFS_PINSTAT);
			chk({7'h0, rd[0]}, {7'h0, auto}, "auto live");
			auto <= ~auto;
			wt(5);
		end
		exp_v = 8'($urandom);
		wr(phc_pkg::OFS_MASK, exp_v);
		rdr(phc_pkg::OFS_MASK);
		chk(rd, exp_v, "mask rw");
		rdr(phc_pkg::OFS_PUSHBUTTON);
		chk(rd, 8'h00, "pushbutton reads zero");
		// each of the four flipped strap bits and three flipped fixed bits must not be acked
		for (int i = 0; i < 7; i++)
		begin
			i_phc_host_model.wr_reg(addr ^ (7'h01 << i), phc_pkg::OFS_MASK, 8'h00, ok);
			chk({7'h0, ok}, 8'h00, "foreign address acked");
		end
		wr(phc_pkg::OFS_MASK, 8'h01);
		pulse(8'hFE);
		wt(5);
		chk({7'h0, ioe}, 8'h00, "masked event");
		for (int k = phc_pkg::PB_RELEASE_LO; k <= phc_pkg::PB_RELEASE_HI; k++)
		begin
			pulse(8'($urandom) | 8'h01);
			wt(5);
			chk({7'h0, ioe}, 8'h01, "event irq");
			wr(phc_pkg::OFS_PUSHBUTTON, 8'h01 << k);
			wt(20);
			chk({7'h0, ioe}, 8'h00, "irq release");
		end
		// event in mid-transaction waits for the stop
		i_phc_host_model.start();
		i_phc_host_model.byte_x({addr, 1'b0}, rd, ok);
		pulse(8'h01);
		wt(20);
		chk({7'h0, ioe}, 8'h00, "irq inside transfer");
		i_phc_host_model.stop();
		wt(20);
		chk({7'h0, ioe}, 8'h01, "irq after stop");
		rdr(phc_pkg::OFS_EVENT);
		chk(rd, 8'h01, "event status");
		wr(phc_pkg::OFS_PUSHBUTTON, 8'h40);
		p = $urandom % 4;
		clr();
		wr(phc_pkg::OFS_PUSHBUTTON, 8'(1 << p));
		chk({4'h0, seen_off}, 8'(1 << p), "pushbutton port off");
		clr();
		off_n[p] <= 1'b0;
		wt(150);
		off_n[p] <= 1'b1;
		wt(10);
		chk({4'h0, seen_off}, 8'h00, "shutdown glitch");
		off_n[p] <= 1'b0;
		wt(260);
		chk({4'h0, port_off}, 8'(1 << p), "shutdown held");
		off_n[p] <= 1'b1;
		wt(220);
		n = 4'($urandom);
		wr(phc_pkg::OFS_ACEN, {4'h0, n});
		wt(3);
		chk({4'h0, acv}, {4'h0, n}, "ac valid");
		osc <= 1'b1;
		wt(3);
		chk({4'h0, acv}, 8'h00, "ac with osc fail");
		osc <= 1'b0;
		chip_reset_n <= 1'b0;
		wt(150);
		chip_reset_n <= 1'b1;
		wt(20);
		rdr(phc_pkg::OFS_MASK);
		chk(rd, 8'h01, "reset glitch");
		pulse(8'h01);
		wt(5);
		chip_reset_n <= 1'b0;
		auto <= ~auto;
		wt(250);
		chk({3'h0, ioe, port_off}, 8'h0F, "held in reset");
		chip_reset_n <= 1'b1;
		wt(220);
		rdr(phc_pkg::OFS_MASK);
		chk(rd, mask_rst(auto), "mask after reset");
		wrap_up();
	end
endmodule : pse_host_control_pins_bench
`default_nettype wire
